// ==== core/trig_countdown.sv ====
// Down counter timing exposure or readout in clock cycles
`timescale 1ns/1ns
module trig_countdown #(
  parameter int W = 32
) (
  input wire logic i_clk_sys,
  input wire logic i_rst_n,
  input wire logic i_start,
  input wire logic [W-1:0] i_len,
  output logic o_done
);
  logic [W-1:0] cnt_q;

  // A zero length still lasts one cycle
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      cnt_q <= '0;
      o_done <= 1'b0;
    end else begin
      o_done <= (cnt_q == W'(1));
      if (i_start) begin
        cnt_q <= (i_len == '0) ? W'(1) : i_len;
      end else if (cnt_q != '0) begin
        cnt_q <= cnt_q - W'(1);
      end
    end
  end

  a_done_once: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    (cnt_q == W'(1)) && !i_start |=> o_done && cnt_q == '0)
    else $error("countdown end not flagged");
endmodule

// ==== core/trig_line_sync.sv ====
// Synchroniser and edge pulses for the hardware trigger line
`timescale 1ns/1ns
module trig_line_sync (
  input wire logic i_clk_sys,
  input wire logic i_rst_n,
  input wire logic i_line,
  input wire logic i_fall_active,
  output logic o_rise,
  output logic o_fall
);
  logic meta_q;
  logic sync_q;
  logic act_q;
  logic act;

  // Polarity change may fake one edge; the bench sets it while armed, in the same write as a stop
  assign act = sync_q ^ i_fall_active;

  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
      act_q <= 1'b0;
      o_rise <= 1'b0;
      o_fall <= 1'b0;
    end else begin
      meta_q <= i_line;
      sync_q <= meta_q;
      act_q <= act;
      o_rise <= act & ~act_q;
      o_fall <= ~act & act_q;
    end
  end

  a_rise_single: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    o_rise |=> !o_rise)
    else $error("trigger pulse longer than one cycle");
endmodule

// ==== core/trig_pkg.sv ====
// Register map, field positions, reset values and states of the sequencer
package trig_pkg;

  // ------------------------------------------------------------
  // Register offsets (byte addresses)
  // ------------------------------------------------------------
  localparam logic [7:0] A_CTRL = 8'h00;
  localparam logic [7:0] A_TRIG = 8'h04;
  localparam logic [7:0] A_FRAMES = 8'h08;
  localparam logic [7:0] A_EXPOSE = 8'h0c;
  localparam logic [7:0] A_READOUT = 8'h10;
  localparam logic [7:0] A_PERIOD = 8'h14;
  localparam logic [7:0] A_STATUS = 8'h18;
  localparam logic [7:0] A_TOTAL = 8'h1c;
  localparam logic [7:0] A_WIDTH = 8'h20;

  // ------------------------------------------------------------
  // Field positions
  // ------------------------------------------------------------
  localparam int C_ARM = 0;
  localparam int C_STOP = 1;
  localparam int C_CONT = 2;
  localparam int C_SEL = 3;
  localparam int C_EXPPW = 4;
  localparam int C_FALL = 5;
  localparam int T_ON = 0;
  localparam int T_SRC = 1;
  localparam int T_FIRE = 2;
  localparam int S_ARMED = 3;
  localparam int S_CNT_LSB = 16;

  // ------------------------------------------------------------
  // Reset values and word transfer size
  // ------------------------------------------------------------
  localparam logic [15:0] FRAMES_RST = 16'h0001;
  localparam logic [31:0] EXPOSE_RST = 32'h0000_03e8;
  localparam logic [31:0] READOUT_RST = 32'h0000_0100;
  localparam logic [31:0] PERIOD_RST = 32'h0000_2710;
  localparam logic [2:0] HSIZE_WORD = 3'h2;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_WAIT_BURST,
    ST_WAIT_FRAME,
    ST_EXPOSE,
    ST_READOUT
  } acq_state_t;

endpackage

// ==== core/trig_sequencer.sv ====
// Two-level acquisition trigger sequencer with AHB-Lite registers
`timescale 1ns/1ns
module trig_sequencer
  import trig_pkg::*;
#(
  parameter int FW = 16,
  parameter int TW = 32
) (
  input wire logic i_clk_sys,
  input wire logic i_rst_n,
  input wire logic i_hsel,
  input wire logic [31:0] i_haddr,
  input wire logic [1:0] i_htrans,
  input wire logic i_hwrite,
  input wire logic [2:0] i_hsize,
  input wire logic [31:0] i_hwdata,
  input wire logic i_hready,
  output logic [31:0] o_hrdata,
  output logic o_hreadyout,
  output logic o_hresp,
  input wire logic i_trig_line,
  output logic o_armed,
  output logic o_wait_burst,
  output logic o_wait_frame,
  output logic o_exposing,
  output logic o_reading
);

  // ------------------------------------------------------------
  // Configuration and command state
  // ------------------------------------------------------------
  logic wr_pend_q;
  logic [7:0] wr_addr_q;
  logic cont_q;
  logic sel_frame_q;
  logic exp_pw_q;
  logic fall_act_q;
  logic burst_on_q;
  logic burst_src_q;
  logic frame_on_q;
  logic frame_src_q;
  logic [FW-1:0] frames_q;
  logic [TW-1:0] exp_len_q;
  logic [TW-1:0] ro_len_q;
  logic [TW-1:0] period_q;
  logic arm_p_q;
  logic stop_p_q;
  logic fire_burst_q;
  logic fire_frame_q;

  // ------------------------------------------------------------
  // Sequencing state
  // ------------------------------------------------------------
  acq_state_t st_q;
  acq_state_t st_d;
  logic [FW-1:0] cnt_q;
  logic [FW-1:0] cnt_d;
  logic stop_pend_q;
  logic pw_q;
  logic [TW-1:0] pace_q;
  logic [31:0] total_q;
  logic [TW-1:0] width_q;
  logic line_rise;
  logic line_fall;
  logic exp_done;
  logic ro_done;
  logic burst_ev;
  logic frame_ev;
  logic pace_hit;
  logic pw_mode;
  logic frame_go;
  logic exp_end;
  logic frame_end;
  logic burst_full;
  logic wr_go;
  logic addr_go;
  logic [31:0] rd_d;
  logic [2:0] st_bits;

  // ------------------------------------------------------------
  // AHB-Lite slave, zero wait states
  // ------------------------------------------------------------
  assign addr_go = i_hsel & i_htrans[1] & i_hready & (i_hsize == HSIZE_WORD);
  assign wr_go = wr_pend_q & i_hready;
  assign st_bits = st_q;

  always_comb begin
    rd_d = '0;
    case (i_haddr[7:0])
      A_CTRL: begin
        rd_d[C_CONT] = cont_q;
        rd_d[C_SEL] = sel_frame_q;
        rd_d[C_EXPPW] = exp_pw_q;
        rd_d[C_FALL] = fall_act_q;
      end
      A_TRIG: begin
        rd_d[T_ON] = sel_frame_q ? frame_on_q : burst_on_q;
        rd_d[T_SRC] = sel_frame_q ? frame_src_q : burst_src_q;
      end
      A_FRAMES: rd_d[FW-1:0] = frames_q;
      A_EXPOSE: rd_d[TW-1:0] = exp_len_q;
      A_READOUT: rd_d[TW-1:0] = ro_len_q;
      A_PERIOD: rd_d[TW-1:0] = period_q;
      A_STATUS: begin
        rd_d[2:0] = st_bits;
        rd_d[S_ARMED] = (st_q != ST_IDLE);
        rd_d[S_CNT_LSB +: FW] = cnt_q;
      end
      A_TOTAL: rd_d = total_q;
      A_WIDTH: rd_d[TW-1:0] = width_q;
      default: rd_d = '0;
    endcase
  end

  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      wr_pend_q <= 1'b0;
      wr_addr_q <= '0;
      o_hrdata <= '0;
      o_hreadyout <= 1'b1;
      o_hresp <= 1'b0;
    end else begin
      o_hreadyout <= 1'b1;
      o_hresp <= 1'b0;
      if (i_hready) begin
        wr_pend_q <= addr_go & i_hwrite;
        wr_addr_q <= i_haddr[7:0];
      end
      if (addr_go && !i_hwrite) begin
        o_hrdata <= rd_d;
      end
    end
  end

  // ------------------------------------------------------------
  // Register writes and command pulses
  // ------------------------------------------------------------
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      cont_q <= 1'b0;
      sel_frame_q <= 1'b0;
      exp_pw_q <= 1'b0;
      fall_act_q <= 1'b0;
      burst_on_q <= 1'b0;
      burst_src_q <= 1'b0;
      frame_on_q <= 1'b0;
      frame_src_q <= 1'b0;
      frames_q <= FRAMES_RST[FW-1:0];
      exp_len_q <= EXPOSE_RST[TW-1:0];
      ro_len_q <= READOUT_RST[TW-1:0];
      period_q <= PERIOD_RST[TW-1:0];
      arm_p_q <= 1'b0;
      stop_p_q <= 1'b0;
      fire_burst_q <= 1'b0;
      fire_frame_q <= 1'b0;
    end else begin
      arm_p_q <= 1'b0;
      stop_p_q <= 1'b0;
      fire_burst_q <= 1'b0;
      fire_frame_q <= 1'b0;
      if (wr_go) begin
        case (wr_addr_q)
          A_CTRL: begin
            arm_p_q <= i_hwdata[C_ARM];
            stop_p_q <= i_hwdata[C_STOP];
            cont_q <= i_hwdata[C_CONT];
            sel_frame_q <= i_hwdata[C_SEL];
            exp_pw_q <= i_hwdata[C_EXPPW];
            fall_act_q <= i_hwdata[C_FALL];
          end
          A_TRIG: begin
            // Shared fields land on the selected trigger only
            if (sel_frame_q) begin
              frame_on_q <= i_hwdata[T_ON];
              frame_src_q <= i_hwdata[T_SRC];
              fire_frame_q <= i_hwdata[T_FIRE];
            end else begin
              burst_on_q <= i_hwdata[T_ON];
              burst_src_q <= i_hwdata[T_SRC];
              fire_burst_q <= i_hwdata[T_FIRE];
            end
          end
          A_FRAMES: frames_q <= i_hwdata[FW-1:0];
          A_EXPOSE: exp_len_q <= i_hwdata[TW-1:0];
          A_READOUT: ro_len_q <= i_hwdata[TW-1:0];
          A_PERIOD: period_q <= i_hwdata[TW-1:0];
          default: ;
        endcase
      end
    end
  end

  a_fire_select: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    wr_go && wr_addr_q == A_TRIG && i_hwdata[T_FIRE] && !sel_frame_q
    |=> fire_burst_q && !fire_frame_q)
    else $error("software fire reached the wrong trigger");

  // ------------------------------------------------------------
  // Trigger sources
  // ------------------------------------------------------------
  trig_line_sync u_line (
    .i_clk_sys(i_clk_sys),
    .i_rst_n(i_rst_n),
    .i_line(i_trig_line),
    .i_fall_active(fall_act_q),
    .o_rise(line_rise),
    .o_fall(line_fall)
  );

  // One pulse per software fire, per valid line pulse or per pace tick
  assign burst_ev = burst_src_q ? line_rise : fire_burst_q;
  assign pace_hit = (pace_q == '0);
  assign frame_ev = frame_on_q ? (frame_src_q ? line_rise : fire_frame_q)
                               : pace_hit;
  assign pw_mode = frame_on_q & frame_src_q & exp_pw_q;

  // Pace counts down while armed and reloads in idle; a frame still busy drops the tick
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      pace_q <= PERIOD_RST[TW-1:0];
    end else if (st_q == ST_IDLE || pace_hit) begin
      pace_q <= period_q;
    end else begin
      pace_q <= pace_q - TW'(1);
    end
  end

  // ------------------------------------------------------------
  // Exposure and readout timing
  // ------------------------------------------------------------
  assign frame_go = (st_q == ST_WAIT_FRAME) & frame_ev & ~stop_p_q;
  assign exp_end = (st_q == ST_EXPOSE) & (pw_q ? line_fall : exp_done);
  assign frame_end = (st_q == ST_READOUT) & ro_done;
  assign burst_full = burst_on_q & (cnt_q >= frames_q);

  trig_countdown #(.W(TW)) u_exp (
    .i_clk_sys(i_clk_sys),
    .i_rst_n(i_rst_n),
    .i_start(frame_go & ~pw_mode),
    .i_len(exp_len_q),
    .o_done(exp_done)
  );

  trig_countdown #(.W(TW)) u_ro (
    .i_clk_sys(i_clk_sys),
    .i_rst_n(i_rst_n),
    .i_start(exp_end),
    .i_len(ro_len_q),
    .o_done(ro_done)
  );

  // ------------------------------------------------------------
  // Acquisition state machine
  // ------------------------------------------------------------
  always_comb begin
    st_d = st_q;
    cnt_d = cnt_q;
    case (st_q)
      ST_IDLE: begin
        // Triggers are not looked at before the arm command
        if (arm_p_q) begin
          st_d = ST_WAIT_BURST;
          cnt_d = '0;
        end
      end
      ST_WAIT_BURST: begin
        if (stop_p_q) begin
          st_d = ST_IDLE;
        end else if (!burst_on_q || burst_ev) begin
          st_d = ST_WAIT_FRAME;
          cnt_d = '0;
        end
      end
      ST_WAIT_FRAME: begin
        if (stop_p_q) begin
          st_d = ST_IDLE;
        end else if (frame_ev) begin
          st_d = ST_EXPOSE;
          cnt_d = cnt_q + FW'(1);
        end
      end
      ST_EXPOSE: begin
        if (exp_end) begin
          st_d = ST_READOUT;
        end
      end
      ST_READOUT: begin
        if (frame_end) begin
          if (!cont_q || stop_pend_q) begin
            st_d = ST_IDLE;
          end else if (burst_full) begin
            st_d = ST_WAIT_BURST;
            cnt_d = '0;
          end else begin
            st_d = ST_WAIT_FRAME;
          end
        end
      end
      default: st_d = ST_IDLE;
    endcase
  end

  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      st_q <= ST_IDLE;
      cnt_q <= '0;
      o_armed <= 1'b0;
      o_wait_burst <= 1'b0;
      o_wait_frame <= 1'b0;
      o_exposing <= 1'b0;
      o_reading <= 1'b0;
    end else begin
      st_q <= st_d;
      cnt_q <= cnt_d;
      o_armed <= (st_d != ST_IDLE);
      o_wait_burst <= (st_d == ST_WAIT_BURST);
      o_wait_frame <= (st_d == ST_WAIT_FRAME);
      o_exposing <= (st_d == ST_EXPOSE);
      o_reading <= (st_d == ST_READOUT);
    end
  end

  // Stop during a frame lets the frame finish first
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      stop_pend_q <= 1'b0;
    end else if (st_d == ST_IDLE) begin
      stop_pend_q <= 1'b0;
    end else if (stop_p_q) begin
      stop_pend_q <= 1'b1;
    end
  end

  // Exposure policy frozen per frame; width counted in clock cycles
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      pw_q <= 1'b0;
      width_q <= '0;
      total_q <= '0;
    end else begin
      if (frame_go) begin
        pw_q <= pw_mode;
        width_q <= '0;
        total_q <= total_q + 32'h0000_0001;
      end else if (st_q == ST_EXPOSE && pw_q && !line_fall) begin
        width_q <= width_q + TW'(1);
      end
    end
  end

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  a_idle_holds: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    st_q == ST_IDLE && !arm_p_q |=> st_q == ST_IDLE)
    else $error("left idle without arm command");

  a_single_stop: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    frame_end && !cont_q |=> st_q == ST_IDLE && !o_armed)
    else $error("single frame policy kept armed");

  a_burst_auto: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    st_q == ST_WAIT_BURST && !burst_on_q && !stop_p_q
    |=> st_q == ST_WAIT_FRAME && o_wait_frame)
    else $error("internal burst start missing");

  a_burst_drop: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    st_q == ST_WAIT_BURST && burst_on_q && !burst_ev && !stop_p_q
    |=> st_q == ST_WAIT_BURST && $stable(total_q))
    else $error("frame accepted while waiting for burst");

  a_burst_go: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    st_q == ST_WAIT_BURST && burst_on_q && burst_ev && !stop_p_q
    |=> st_q == ST_WAIT_FRAME && cnt_q == '0)
    else $error("burst trigger not taken");

  a_burst_end: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    frame_end && cont_q && !stop_pend_q && burst_full
    |=> st_q == ST_WAIT_BURST && cnt_q == '0)
    else $error("burst did not end at frame count");

  a_frame_go: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    frame_go |=> st_q == ST_EXPOSE
    && cnt_q == $past(cnt_q) + FW'(1))
    else $error("frame trigger did not start exposure");

  a_frame_back: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    frame_end && cont_q && !stop_pend_q && !burst_full
    |=> st_q == ST_WAIT_FRAME)
    else $error("no return to frame wait");

  a_frame_drop: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    (st_q == ST_EXPOSE || st_q == ST_READOUT) && frame_ev && !frame_end
    |=> $stable(cnt_q) && $stable(total_q))
    else $error("frame trigger taken while busy");

  a_pw_end: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    st_q == ST_EXPOSE && pw_q && line_fall
    |=> st_q == ST_READOUT ##1 o_reading)
    else $error("pulse width exposure did not end on line edge");

endmodule

// ==== verif/acquisition_trigger_sequencer_tb.sv ====
// Self-checking bench for the acquisition trigger sequencer
`timescale 1ns/1ns
module acquisition_trigger_sequencer_tb
  import trig_pkg::*;
;
  typedef struct packed {logic [7:0] a; logic [31:0] e;} row_t;
  row_t rows [10] = '{
    '{A_CTRL, 32'h0000_0000}, '{A_TRIG, 32'h0000_0000},
    '{A_FRAMES, {16'h0000, FRAMES_RST}}, '{A_EXPOSE, EXPOSE_RST},
    '{A_READOUT, READOUT_RST}, '{A_PERIOD, PERIOD_RST},
    '{A_STATUS, 32'h0000_0000}, '{A_TOTAL, 32'h0000_0000},
    '{A_WIDTH, 32'h0000_0000}, '{8'h24, 32'h0000_0000}};
  logic i_clk_sys, i_rst_n, hsel, hwrite, go, hready, hresp, line, fall;
  logic armed, wb, wf, ex, rd;
  logic [31:0] haddr, hwdata, hrdata, d;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [15:0] len;
  logic [4:0] st;
  int errors, compares, exp_run, last_exp;
  assign st = {rd, ex, wf, wb, armed};

  trig_sequencer #(.FW(16), .TW(32)) trig_sequencer_i (
    .i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n), .i_hsel(hsel),
    .i_haddr(haddr), .i_htrans(htrans), .i_hwrite(hwrite),
    .i_hsize(hsize), .i_hwdata(hwdata), .i_hready(hready),
    .o_hrdata(hrdata), .o_hreadyout(hready), .o_hresp(hresp),
    .i_trig_line(line), .o_armed(armed), .o_wait_burst(wb),
    .o_wait_frame(wf), .o_exposing(ex), .o_reading(rd));
  trig_line_drv trig_line_drv_i (
    .i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n), .i_go(go), .i_len(len),
    .i_fall_active(fall), .o_line(line), .o_busy());

  initial begin
    i_clk_sys = 1'b0;
    forever #5 i_clk_sys = ~i_clk_sys;
  end

  // Length of the last finished exposure, in clock cycles
  always @(posedge i_clk_sys) begin
    if (ex === 1'b1) begin
      exp_run <= exp_run + 1;
    end else if (exp_run != 0) begin
      last_exp <= exp_run;
      exp_run <= 0;
    end
  end

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    compares++;
    if (g !== e) begin
      errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  task automatic chk_rng(input logic [31:0] g, input logic [31:0] lo,
                         input logic [31:0] hi);
    compares++;
    if ((g >= lo && g <= hi) !== 1'b1) begin
      errors++;
      $display("MISMATCH t=%0t got=%h exp=%h..%h", $time, g, lo, hi);
    end
  endtask

  task automatic ahb_write(input logic [7:0] a, input logic [31:0] v);
    @(posedge i_clk_sys);
    haddr <= {24'h00_0000, a};
    htrans <= 2'h2;
    hwrite <= 1'b1;
    do @(posedge i_clk_sys); while (hready !== 1'b1);
    htrans <= 2'h0;
    hwdata <= v;
    do @(posedge i_clk_sys); while (hready !== 1'b1);
  endtask

  task automatic ahb_read(input logic [7:0] a, output logic [31:0] v);
    @(posedge i_clk_sys);
    haddr <= {24'h00_0000, a};
    htrans <= 2'h2;
    hwrite <= 1'b0;
    do @(posedge i_clk_sys); while (hready !== 1'b1);
    htrans <= 2'h0;
    do @(posedge i_clk_sys); while (hready !== 1'b1);
    v = hrdata;
  endtask

  // Bounded wait for an exact status pattern
  task automatic wait_eq(input logic [4:0] m, input int n);
    int i;
    i = 0;
    do begin
      @(posedge i_clk_sys);
      i++;
    end while (st !== m && i < n);
    chk({27'h000_0000, st}, {27'h000_0000, m});
  endtask

  task automatic pulse(input logic [15:0] w);
    go <= 1'b1;
    len <= w;
    @(posedge i_clk_sys);
    go <= 1'b0;
  endtask

  task automatic test_done;
    $display("errors=%0d compares=%0d", errors, compares);
    if (errors == 0 && compares > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge i_clk_sys);
    errors++;
    test_done;
  end

  initial begin
    {i_rst_n, hsel, hwrite, go, fall, htrans, haddr, hwdata, len} = '0;
    hsize = HSIZE_WORD;
    {errors, compares, exp_run, last_exp} = '0;
    repeat (16) @(posedge i_clk_sys);
    i_rst_n <= 1'b1;
    hsel <= 1'b1;
    @(posedge i_clk_sys);
    chk({26'h000_0000, hresp, st}, 32'h0000_0000);
    for (int k = 0; k < 10; k++) begin
      ahb_read(rows[k].a, d);
      chk(d, rows[k].e);
    end
    // ------------------------------------------------------------
    // Burst with software-fired triggers
    // ------------------------------------------------------------
    ahb_write(A_CTRL, 32'h0000_000c);
    ahb_write(A_TRIG, 32'h0000_0005);
    repeat (10) @(posedge i_clk_sys);
    chk({27'h000_0000, st}, 32'h0000_0000);
    ahb_write(A_FRAMES, 32'h0000_0002);
    ahb_write(A_EXPOSE, 32'h0000_0005);
    ahb_write(A_READOUT, 32'h0000_0005);
    ahb_write(A_CTRL, 32'h0000_0004);
    ahb_write(A_TRIG, 32'h0000_0003);
    ahb_write(A_CTRL, 32'h0000_000c);
    ahb_read(A_TRIG, d);
    chk(d, 32'h0000_0001);
    ahb_write(A_TRIG, 32'h0000_0001);
    ahb_write(A_CTRL, 32'h0000_000d);
    wait_eq(5'b00011, 8);
    ahb_write(A_TRIG, 32'h0000_0005);
    repeat (8) @(posedge i_clk_sys);
    chk({27'h000_0000, st}, 32'h0000_0003);
    ahb_write(A_CTRL, 32'h0000_0004);
    ahb_write(A_TRIG, 32'h0000_0005);
    wait_eq(5'b00101, 8);
    ahb_write(A_CTRL, 32'h0000_000c);
    ahb_write(A_TRIG, 32'h0000_0005);
    wait_eq(5'b01001, 8);
    ahb_write(A_TRIG, 32'h0000_0005);
    wait_eq(5'b00101, 30);
    chk_rng(last_exp, 5, 7);
    ahb_read(A_TOTAL, d);
    chk(d, 32'h0000_0001);
    ahb_write(A_TRIG, 32'h0000_0005);
    wait_eq(5'b01001, 8);
    wait_eq(5'b00011, 30);
    ahb_write(A_CTRL, 32'h0000_000e);
    wait_eq(5'b00000, 8);
    // ------------------------------------------------------------
    // Single frame, both triggers internal
    // ------------------------------------------------------------
    ahb_write(A_CTRL, 32'h0000_0004);
    ahb_write(A_TRIG, 32'h0000_0000);
    ahb_write(A_CTRL, 32'h0000_0008);
    ahb_write(A_TRIG, 32'h0000_0000);
    ahb_write(A_PERIOD, 32'h0000_0008);
    ahb_write(A_CTRL, 32'h0000_0009);
    wait_eq(5'b01001, 40);
    wait_eq(5'b00000, 40);
    repeat (30) @(posedge i_clk_sys);
    chk({27'h000_0000, st}, 32'h0000_0000);
    ahb_read(A_TOTAL, d);
    chk(d, 32'h0000_0003);
    // ------------------------------------------------------------
    // Line trigger: pulse width, then timed exposure
    // ------------------------------------------------------------
    ahb_write(A_CTRL, 32'h0000_001c);
    ahb_write(A_TRIG, 32'h0000_0003);
    ahb_write(A_CTRL, 32'h0000_001d);
    wait_eq(5'b00101, 8);
    pulse(16'h0014);
    wait_eq(5'b01001, 10);
    wait_eq(5'b10001, 40);
    @(posedge i_clk_sys);
    chk_rng(last_exp, 19, 21);
    ahb_read(A_WIDTH, d);
    chk_rng(d, 19, 21);
    wait_eq(5'b00101, 40);
    ahb_write(A_CTRL, 32'h0000_000c);
    pulse(16'h0003);
    wait_eq(5'b01001, 10);
    wait_eq(5'b00101, 40);
    chk_rng(last_exp, 5, 7);
    // ------------------------------------------------------------
    // Falling-edge line, single frame; polarity changed while armed, in the same write as the stop command
    // ------------------------------------------------------------
    fall <= 1'b1;
    ahb_write(A_CTRL, 32'h0000_002a);
    wait_eq(5'b00000, 8);
    repeat (4) @(posedge i_clk_sys);
    ahb_write(A_CTRL, 32'h0000_0029);
    wait_eq(5'b00101, 8);
    pulse(16'h0003);
    wait_eq(5'b01001, 10);
    wait_eq(5'b00000, 40);
    test_done;
  end
endmodule

// ==== verif/trig_line_drv.sv ====
// Behavioural model of the party driving hardware trigger line 1
`timescale 1ns/1ns
module trig_line_drv #(
  parameter int GAP = 4
) (
  input wire logic i_clk_sys,
  input wire logic i_rst_n,
  input wire logic i_go,
  input wire logic [15:0] i_len,
  input wire logic i_fall_active,
  output logic o_line,
  output logic o_busy
);
  logic [15:0] cnt_q;
  logic [15:0] gap_q;

  // One clean pulse per request, never overlapping
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      cnt_q <= 16'h0000;
    end else if (i_go && !o_busy) begin
      cnt_q <= i_len;
    end else if (cnt_q != 16'h0000) begin
      cnt_q <= cnt_q - 16'h0001;
    end
  end

  // Idle spacing keeps pulses under the allowed rate
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      gap_q <= 16'h0000;
    end else if (cnt_q == 16'h0001) begin
      gap_q <= 16'(GAP);
    end else if (gap_q != 16'h0000) begin
      gap_q <= gap_q - 16'h0001;
    end
  end

  assign o_busy = (cnt_q != 16'h0000) || (gap_q != 16'h0000);
  assign o_line = (cnt_q != 16'h0000) ^ i_fall_active;
endmodule
